// file: prhc_pkg.sv
// Package for the reference input and holdover register block
package prhc_pkg;

  // Register indices and their byte addresses on the APB bus
  localparam int unsigned  ADDR_W       = 8;
  localparam int unsigned  ADDR_SHIFT   = 2;
  localparam logic [7:0]   REF_CFG_IDX  = 8'h1c;
  localparam logic [7:0]   HO_CFG_IDX   = 8'h1d;
  localparam logic [7:0]   STAT_IDX     = 8'h1f;
  localparam logic [ADDR_W-1:0] REF_CFG_ADDR =
    ADDR_W'(REF_CFG_IDX << ADDR_SHIFT);
  localparam logic [ADDR_W-1:0] HO_CFG_ADDR  =
    ADDR_W'(HO_CFG_IDX << ADDR_SHIFT);
  localparam logic [ADDR_W-1:0] STAT_ADDR    =
    ADDR_W'(STAT_IDX << ADDR_SHIFT);

  // Field positions
  localparam int unsigned  SECONDARY_REFERENCE_INPUT_PWR_BIT = 2;
  localparam int unsigned  PRIMARY_REFERENCE_INPUT_PWR_BIT = 1;
  localparam int unsigned  DIFF_BIT     = 0;
  localparam int unsigned  STAT_DIS_BIT = 4;
  localparam int unsigned  LDCMP_BIT    = 3;
  localparam int unsigned  HOEN_HI_BIT  = 2;
  localparam int unsigned  EXTHO_BIT    = 1;
  localparam int unsigned  HOEN_LO_BIT  = 0;
  localparam int unsigned  CAL_BIT      = 6;
  localparam int unsigned  HOACT_BIT    = 5;
  localparam int unsigned  REF2SEL_BIT  = 4;
  localparam int unsigned  VCOTH_BIT    = 3;

  // Widths and reset values of the writable fields
  localparam int unsigned  DATA_W       = 32;
  localparam int unsigned  STAT_W       = 8;
  localparam int unsigned  REF_CFG_W    = 3;
  localparam int unsigned  HO_CFG_W     = 5;
  localparam logic [REF_CFG_W-1:0] REF_CFG_RST = 3'h0;
  localparam logic [HO_CFG_W-1:0]  HO_CFG_RST  = 5'h0;

  // Positions inside the synchronised status vector
  localparam int unsigned  STAT_N       = 5;
  localparam int unsigned  IN_CAL       = 0;
  localparam int unsigned  IN_HOACT     = 1;
  localparam int unsigned  IN_REF2SEL   = 2;
  localparam int unsigned  IN_VCOTH     = 3;
  localparam int unsigned  IN_LDCMP     = 4;

  typedef struct packed {
    logic ldCompOut;
    logic vcoAboveThreshold;
    logic secondarySelected;
    logic holdoverActive;
    logic vcoCalDone;
  } prhc_stat_s;

  typedef struct packed {
    logic secondaryRefPowerOn;
    logic primaryRefPowerOn;
    logic diffRefMode;
    logic ldCompEnable;
    logic holdoverEnabled;
    logic extHoldoverCtrl;
    logic autoHoldoverRun;
    logic autoLockSense;
    logic refMonLd;
  } prhc_ctrl_s;

  typedef struct packed {
    logic [REF_CFG_W-1:0] refCfg;
    logic [HO_CFG_W-1:0]  hoCfg;
    logic [STAT_N-1:0]    s1;
    logic [STAT_N-1:0]    s2;
    logic [STAT_N-1:0]    s3;
    logic [STAT_N-1:0]    filt;
    logic [DATA_W-1:0]    rdata;
    logic                 slvErr;
    prhc_ctrl_s           ctrl;
  } prhc_state_s;

  localparam prhc_state_s STATE_RST = '{
    refCfg: REF_CFG_RST,
    hoCfg:  HO_CFG_RST,
    // Comparator off at reset, so the lock pin already counts as high
    ctrl:   '{autoLockSense: 1'b1, default: 1'b0},
    default: '0
  };

endpackage

// file: prhc_regs.sv
// APB register block for reference inputs, holdover control and status
`timescale 1ns/1ns
`default_nettype none

module prhc_regs
  import prhc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire prhc_stat_s        statIn,
  output var  prhc_ctrl_s        ctrlOut
);

  prhc_state_s st_q;
  prhc_state_s st_d;
  logic        setupPh;
  logic        accessPh;
  logic [STAT_W-1:0] statWord;

  assign setupPh  = psel & ~penable & ce;
  assign accessPh = psel & penable & ce;
  // Freezes the bus handshake together with all state
  assign pready   = ce;
  assign pslverr  = st_q.slvErr & psel & penable;
  assign prdata   = st_q.rdata;
  assign ctrlOut  = st_q.ctrl;

  always_comb
  begin
    statWord = '0;
    statWord[CAL_BIT]     = st_q.filt[IN_CAL];
    statWord[HOACT_BIT]   = st_q.filt[IN_HOACT];
    // Differential mode always reads primary
    statWord[REF2SEL_BIT] = st_q.filt[IN_REF2SEL] &
                            ~st_q.refCfg[DIFF_BIT];
    statWord[VCOTH_BIT]   = st_q.filt[IN_VCOTH];
  end

  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      // Pin synchronisers, a change counts once stages two and three agree
      st_d.s1   = statIn;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.filt = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) |
                  (st_q.filt & (st_q.s2 ^ st_q.s3));

      if (setupPh)
      begin
        st_d.rdata  = '0;
        st_d.slvErr = 1'b0;
        unique case (paddr)
          REF_CFG_ADDR:
            st_d.rdata[REF_CFG_W-1:0] = st_q.refCfg;
          HO_CFG_ADDR:
            st_d.rdata[HO_CFG_W-1:0] = st_q.hoCfg;
          STAT_ADDR:
            if (!st_q.hoCfg[STAT_DIS_BIT])
            begin
              st_d.rdata[STAT_W-1:0] = statWord;
            end
          default:
            st_d.slvErr = 1'b1;
        endcase
      end

      if (accessPh && pwrite)
      begin
        unique case (paddr)
          REF_CFG_ADDR:
            st_d.refCfg = pwdata[REF_CFG_W-1:0];
          HO_CFG_ADDR:
            st_d.hoCfg = pwdata[HO_CFG_W-1:0];
          default:
            st_d.refCfg = st_q.refCfg;
        endcase
      end

      st_d.ctrl.secondaryRefPowerOn = st_d.refCfg[SECONDARY_REFERENCE_INPUT_PWR_BIT];
      st_d.ctrl.primaryRefPowerOn   = st_d.refCfg[PRIMARY_REFERENCE_INPUT_PWR_BIT];
      st_d.ctrl.diffRefMode         = st_d.refCfg[DIFF_BIT];
      st_d.ctrl.ldCompEnable        = st_d.hoCfg[LDCMP_BIT];
      st_d.ctrl.holdoverEnabled     = st_d.hoCfg[HOEN_HI_BIT] &
                                      st_d.hoCfg[HOEN_LO_BIT];
      st_d.ctrl.extHoldoverCtrl     = st_d.hoCfg[EXTHO_BIT];
      st_d.ctrl.autoHoldoverRun     = st_d.ctrl.holdoverEnabled &
                                      ~st_d.hoCfg[EXTHO_BIT];
      // Comparator off means the pin counts as high
      st_d.ctrl.autoLockSense       = ~st_d.hoCfg[LDCMP_BIT] |
                                      st_d.filt[IN_LDCMP];
      st_d.ctrl.refMonLd            = st_d.hoCfg[LDCMP_BIT] &
                                      ~st_d.ctrl.autoHoldoverRun &
                                      st_d.filt[IN_LDCMP];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= STATE_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic wrRef;
  logic wrHo;
  logic wrStat;
  logic rdStat;
  logic badAddr;
  assign wrRef  = accessPh & pwrite & (paddr == REF_CFG_ADDR);
  assign wrHo   = accessPh & pwrite & (paddr == HO_CFG_ADDR);
  assign wrStat = accessPh & pwrite & (paddr == STAT_ADDR);
  assign rdStat = setupPh & ~pwrite & (paddr == STAT_ADDR);
  assign badAddr = (paddr != REF_CFG_ADDR) & (paddr != HO_CFG_ADDR) &
                   (paddr != STAT_ADDR);

  a_secondary_reference_input_power: assert property (
    wrRef |=> ctrlOut.secondaryRefPowerOn == $past(pwdata[SECONDARY_REFERENCE_INPUT_PWR_BIT]))
    else $error("secondary reference power does not follow write");

  a_primary_reference_input_power: assert property (
    wrRef |=> ctrlOut.primaryRefPowerOn == $past(pwdata[PRIMARY_REFERENCE_INPUT_PWR_BIT]))
    else $error("primary reference power does not follow write");

  a_diff_mode: assert property (
    wrRef ##1 (!wrRef)[*2] |->
      ctrlOut.diffRefMode == $past(pwdata[DIFF_BIT], 2))
    else $error("reference mode not held after write");

  a_stat_disable: assert property (
    (rdStat && st_q.hoCfg[STAT_DIS_BIT]) |=> prdata == '0)
    else $error("status readback not blocked");

  a_ldcmp_off_high: assert property (
    !ctrlOut.ldCompEnable |-> ctrlOut.autoLockSense)
    else $error("lock sense not high with comparator off");

  a_ldcmp_use_pin: assert property (
    ctrlOut.ldCompEnable |->
      ctrlOut.autoLockSense == st_q.filt[IN_LDCMP])
    else $error("lock sense does not follow pin comparator");

  a_ho_both_bits: assert property (
    wrHo |=> ctrlOut.holdoverEnabled ==
      ($past(pwdata[HOEN_HI_BIT]) & $past(pwdata[HOEN_LO_BIT])))
    else $error("holdover enable not the and of both bits");

  a_ext_ho_ctrl: assert property (
    ctrlOut.autoHoldoverRun |->
      (!ctrlOut.extHoldoverCtrl && ctrlOut.holdoverEnabled))
    else $error("internal holdover runs under pin control");

  a_cal_status: assert property (
    (rdStat && !st_q.hoCfg[STAT_DIS_BIT]) |=>
      prdata[CAL_BIT] == $past(st_q.filt[IN_CAL]))
    else $error("calibration status bit wrong");

  a_ho_active: assert property (
    (rdStat && !st_q.hoCfg[STAT_DIS_BIT]) |=>
      prdata[HOACT_BIT] == $past(st_q.filt[IN_HOACT]))
    else $error("holdover active bit wrong");

  a_secondary_reference_input_sel: assert property (
    (rdStat && st_q.refCfg[DIFF_BIT]) |=> !prdata[REF2SEL_BIT])
    else $error("secondary selected shown in differential mode");

  a_vco_thresh: assert property (
    (rdStat && !st_q.hoCfg[STAT_DIS_BIT]) |=>
      prdata[VCOTH_BIT] == $past(st_q.filt[IN_VCOTH]))
    else $error("vco threshold bit wrong");

  a_vco_filter: assert property (
    (ce && st_q.s2[IN_VCOTH] == st_q.s3[IN_VCOTH]) |=>
      st_q.filt[IN_VCOTH] == $past(st_q.s2[IN_VCOTH]))
    else $error("vco threshold filter does not settle");

  a_stat_ro: assert property (
    wrStat |=> ($stable(st_q.refCfg) && $stable(st_q.hoCfg)))
    else $error("status write changed configuration");

  // Configuration changes only through a write to its own address
  a_ref_cfg_hold: assert property (
    !wrRef |=>
      $stable(st_q.refCfg))
    else $error("reference config changed without a write");

  a_ref_cfg_write: assert property (
    wrRef |=>
      st_q.refCfg == $past(pwdata[REF_CFG_W-1:0]))
    else $error("reference config does not take written value");

  a_ho_cfg_hold: assert property (
    !wrHo |=>
      $stable(st_q.hoCfg))
    else $error("holdover config changed without a write");

  a_ho_cfg_write: assert property (
    wrHo |=>
      st_q.hoCfg == $past(pwdata[HO_CFG_W-1:0]))
    else $error("holdover config does not take written value");

  a_ldcmp_enable: assert property (
    wrHo |=>
      ctrlOut.ldCompEnable == $past(pwdata[LDCMP_BIT]))
    else $error("comparator enable does not follow write");

  a_ldcmp_off_write: assert property (
    (wrHo && !pwdata[LDCMP_BIT]) |=>
      ctrlOut.autoLockSense)
    else $error("lock sense not high after comparator disabled");

  a_ext_ho_write: assert property (
    wrHo |=>
      ctrlOut.extHoldoverCtrl == $past(pwdata[EXTHO_BIT]))
    else $error("external holdover control does not follow write");

  a_auto_run_write: assert property (
    wrHo |=> ctrlOut.autoHoldoverRun == ($past(pwdata[HOEN_HI_BIT]) &
      $past(pwdata[HOEN_LO_BIT]) & !$past(pwdata[EXTHO_BIT])))
    else $error("automatic holdover run state wrong after write");

  // Lock pin routing
  a_ldcmp_settle: assert property (
    (ce && ctrlOut.ldCompEnable && !wrHo &&
      st_q.s2[IN_LDCMP] == st_q.s3[IN_LDCMP]) |=>
      ctrlOut.autoLockSense == $past(st_q.s2[IN_LDCMP]))
    else $error("lock sense does not settle to pin level");

  a_reference_monitor_pin_auto: assert property (
    ctrlOut.autoHoldoverRun |->
      !ctrlOut.refMonLd)
    else $error("monitor routing active in automatic holdover");

  a_reference_monitor_pin_off: assert property (
    !ctrlOut.ldCompEnable |->
      !ctrlOut.refMonLd)
    else $error("monitor routing active with comparator off");

  // Status readback and bus response
  a_secondary_reference_input_sel_read: assert property (
    (rdStat && !st_q.hoCfg[STAT_DIS_BIT] && !st_q.refCfg[DIFF_BIT]) |=>
      prdata[REF2SEL_BIT] == $past(st_q.filt[IN_REF2SEL]))
    else $error("secondary selected bit wrong in single-ended mode");

  a_stat_dis_err: assert property (
    (rdStat && st_q.hoCfg[STAT_DIS_BIT]) |=>
      !pslverr)
    else $error("blocked status read gives an error");

  a_stat_wr_ok: assert property (
    wrStat |-> !pslverr)
    else $error("status write gives an error");

  a_rdata_upper: assert property (
    (psel && penable) |->
      prdata[DATA_W-1:STAT_W] == '0)
    else $error("unused read data bits not zero");

  a_rdata_hold: assert property (
    !setupPh |=>
      $stable(prdata))
    else $error("read data changed outside a setup cycle");

  a_bad_addr_err: assert property (
    (setupPh && badAddr) |=>
      pslverr)
    else $error("unmapped address gives no error");

  a_good_addr_ok: assert property (
    (setupPh && !badAddr) |=>
      !pslverr)
    else $error("mapped address gives an error");

  a_slverr_idle: assert property (
    !(psel && penable) |-> !pslverr)
    else $error("error shown outside an access phase");

  // Clock enable and pin synchronisers
  a_ce_freeze: assert property (
    !ce |=>
      $stable(st_q))
    else $error("state changed with clock enable low");

  a_sync_agree: assert property (
    ce |=> ((st_q.filt ^ $past(st_q.s2)) &
      ~($past(st_q.s2) ^ $past(st_q.s3))) == '0)
    else $error("synchronised status ignores agreeing stages");

  a_sync_hold: assert property (
    ce |=> ((st_q.filt ^ $past(st_q.filt)) &
      ($past(st_q.s2) ^ $past(st_q.s3))) == '0)
    else $error("synchronised status moves while stages disagree");

  c_stat_read: cover property (
    rdStat && !st_q.hoCfg[STAT_DIS_BIT] ##1 accessPh);
  c_ho_enable: cover property (
    wrHo ##1 ctrlOut.holdoverEnabled);
  c_auto_ldcmp: cover property (
    ctrlOut.autoHoldoverRun && ctrlOut.ldCompEnable);
  c_bad_addr: cover property (pslverr && pready);
  c_diff_masked: cover property (
    rdStat && st_q.refCfg[DIFF_BIT] && st_q.filt[IN_REF2SEL]);

endmodule // prhc_regs

`default_nettype wire

// file: tb.sv
// Self-checking testbench for the reference and holdover register block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import prhc_pkg::*;
  localparam int LIMIT = 3000;
  logic              clk, rst_b, ce, psel, penable, pwrite, pready, pslverr;
  logic              er;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  prhc_stat_s        statIn;
  prhc_ctrl_s        ctrlOut;
  int                err_count, check_count, cycles;

  prhc_regs prhc_regs_i (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .statIn(statIn),
    .ctrlOut(ctrlOut));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset;
    apb(1'b0, REF_CFG_ADDR, 32'h0);
    chk(rd, 32'h0, "ref cfg reset");
    apb(1'b0, HO_CFG_ADDR, 32'h0);
    chk(rd, 32'h0, "holdover cfg reset");
    chk(32'(ctrlOut.holdoverEnabled), 32'h0, "holdover off");
    chk(32'(ctrlOut.autoLockSense), 32'h1, "pin seen high");
    $display("test reset done");
  endtask

  task automatic t_refcfg;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, REF_CFG_ADDR, 32'h1 << i);
      apb(1'b0, REF_CFG_ADDR, 32'h0);
      chk(rd, 32'h1 << i, "ref cfg readback");
      chk(32'({ctrlOut.secondaryRefPowerOn, ctrlOut.primaryRefPowerOn,
        ctrlOut.diffRefMode}), 32'h1 << i, "ref ctrl");
    end
    apb(1'b1, REF_CFG_ADDR, 32'hffffffff);
    apb(1'b0, REF_CFG_ADDR, 32'h0);
    chk(rd, 32'h7, "ref cfg width");
    $display("test reference config done");
  endtask

  task automatic t_holdover;
    logic [4:0] cfg [5] = '{5'h01, 5'h04, 5'h05, 5'h07, 5'h06};
    logic [2:0] exp [5] = '{3'h0, 3'h0, 3'h5, 3'h6, 3'h2};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, HO_CFG_ADDR, 32'(cfg[i]));
      apb(1'b0, HO_CFG_ADDR, 32'h0);
      chk(rd, 32'(cfg[i]), "holdover readback");
      chk(32'({ctrlOut.holdoverEnabled, ctrlOut.extHoldoverCtrl,
        ctrlOut.autoHoldoverRun}), 32'(exp[i]), "holdover");
    end
    statIn <= prhc_stat_s'(5'h00);
    apb(1'b1, HO_CFG_ADDR, 32'h0);
    repeat (8) @(posedge clk);
    chk(32'(ctrlOut.autoLockSense), 32'h1, "comparator off");
    apb(1'b1, HO_CFG_ADDR, 32'h08);
    chk(32'({ctrlOut.ldCompEnable, ctrlOut.autoLockSense}), 32'h2,
      "pin low used");
    statIn <= prhc_stat_s'(5'h10);
    repeat (8) @(posedge clk);
    chk(32'({ctrlOut.autoLockSense, ctrlOut.refMonLd}), 32'h3,
      "pin high");
    apb(1'b1, HO_CFG_ADDR, 32'h0d);
    chk(32'(ctrlOut.refMonLd), 32'h0, "monitor off in auto");
    $display("test holdover done");
  endtask

  task automatic t_status;
    apb(1'b1, HO_CFG_ADDR, 32'h0);
    apb(1'b1, REF_CFG_ADDR, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      statIn <= prhc_stat_s'(5'h1 << i);
      repeat (8) @(posedge clk);
      apb(1'b0, STAT_ADDR, 32'h0);
      chk(rd, 32'h1 << (6 - i), "status bit");
    end
    statIn <= prhc_stat_s'(5'h0f);
    repeat (8) @(posedge clk);
    apb(1'b1, STAT_ADDR, 32'h0);
    chk(32'(er), 32'h0, "status write no error");
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd, 32'h78, "status after write");
    apb(1'b1, REF_CFG_ADDR, 32'h1);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd, 32'h68, "secondary hidden in diff");
    apb(1'b1, HO_CFG_ADDR, 32'h10);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd, 32'h0, "readback disabled");
    $display("test status done");
  endtask

  task automatic t_freeze;
    apb(1'b1, HO_CFG_ADDR, 32'h08);
    statIn <= prhc_stat_s'(5'h00);
    repeat (8) @(posedge clk);
    chk(32'(ctrlOut.autoLockSense), 32'h0, "pin low before freeze");
    ce <= 1'b0;
    statIn <= prhc_stat_s'(5'h10);
    repeat (8) @(posedge clk);
    chk(32'({pready, ctrlOut.autoLockSense}), 32'h0, "frozen");
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(ctrlOut.autoLockSense), 32'h1, "pin high after freeze");
    $display("test freeze done");
  endtask

  task automatic t_unmapped;
    apb(1'b1, 8'h78, 32'h1);
    chk(32'(er), 32'h1, "unmapped write error");
    apb(1'b0, 8'h78, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    $display("test unmapped done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    statIn = prhc_stat_s'(5'h00);
    err_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_refcfg();
    t_holdover();
    t_status();
    t_freeze();
    t_unmapped();
    // Second reset in mid-run, configuration must return to defaults
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    end_sim();
  end
endmodule // tb
`default_nettype wire
